// *** logic/poc_pkg.sv ***
package poc_pkg;
  // Channel modes
  typedef enum logic [2:0] {
    POC_MODE_PWM,
    POC_MODE_FREQ,
    POC_MODE_TRAIN_PULSE_DIR,
    POC_MODE_TRAIN_UP_DOWN,
    POC_MODE_TRAIN_PHASE,
    POC_MODE_TRAIN_PHASE_X4
  } poc_mode_t;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] PERIOD_ADDR = 8'h04;
  localparam logic [7:0] ON_ADDR     = 8'h08;
  localparam logic [7:0] STEP_ADDR   = 8'h0C;
  localparam logic [7:0] STATUS_ADDR = 8'h10;

  // Control field positions
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_OWNER_BIT   = 1;
  localparam int CTRL_LEVEL_BIT   = 3;
  localparam int CTRL_FAST_BIT    = 4;
  localparam int CTRL_DRVCFG_BIT  = 5;
  localparam int CTRL_DIR_BIT     = 6;
  localparam int CTRL_MODE_LSB    = 8;
  localparam int CTRL_MODE_MSB    = 10;

  // Status field positions
  localparam int STS_ACTIVE_BIT   = 0;
  localparam int STS_STOP_BIT     = 1;
  localparam int STS_A_BIT        = 2;
  localparam int STS_B_BIT        = 3;
  localparam int STS_DRV_BIT      = 4;
  localparam int STS_FAST_BIT     = 5;

  // Reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0002;
  localparam logic [31:0] PERIOD_RESET = 32'h0000_0064;
  localparam logic [31:0] ON_RESET     = 32'h0000_0032;
  localparam logic [31:0] STEP_RESET   = 32'h0000_0032;

  // Timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int FAST_MAX_HZ     = 100_000;
  localparam int SLOW_MAX_HZ     = 100;
  localparam int FAST_MIN_CYCLES = (CLK_HZ + 2 * FAST_MAX_HZ - 1) / (2 * FAST_MAX_HZ);
  localparam int SLOW_MIN_CYCLES = (CLK_HZ + 2 * SLOW_MAX_HZ - 1) / (2 * SLOW_MAX_HZ);
endpackage : poc_pkg

// *** logic/poc_rate_limit.sv ***
`timescale 1ns/1ps
// Holds each output level for at least MIN_CYCLES clocks
module poc_rate_limit #(
  parameter int MIN_CYCLES = 1
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Levels
  input  wire logic level_in,
  output logic      level_out
);
  localparam int CW = $clog2(MIN_CYCLES + 1);

  logic [CW-1:0] hold_cnt;
  logic [CW-1:0] next_hold_cnt;
  logic          next_level_out;

  always_comb begin
    next_hold_cnt  = hold_cnt;
    next_level_out = level_out;
    if (hold_cnt != '0) begin
      next_hold_cnt = hold_cnt - CW'(1);
    end else if (level_in != level_out) begin
      next_level_out = level_in;
      next_hold_cnt  = CW'(MIN_CYCLES - 1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt  <= '0;
      level_out <= 1'b0;
    end else begin
      hold_cnt  <= next_hold_cnt;
      level_out <= next_level_out;
    end
  end
endmodule : poc_rate_limit

// *** logic/poc_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages two and three agree
module poc_sync (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Levels
  input  wire logic async_in,
  output logic      sync_out
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_sync_out;

  always_comb begin
    next_stage    = {stage[1:0], async_in};
    next_sync_out = (stage[1] == stage[2]) ? stage[2] : sync_out;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage    <= 3'b000;
      sync_out <= 1'b0;
    end else begin
      stage    <= next_stage;
      sync_out <= next_sync_out;
    end
  end
endmodule : poc_sync

// *** logic/poc_channel.sv ***
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - On stop drop drive enable, zero velocity
// - Tracks may go high on stop
// - Track outputs are fast, up to 100 kHz
// - Drive enable is slow, 100 Hz limited
// - Track B on own output in variants
// - Pulse-train modes always use fast stage
// - Fast stage selectable at run in PWM/frequency
// - Direct control only in PWM/frequency modes
// - Owner select 0 routes direct level
// - Direct mode output follows direct level
// - Generator keeps running under direct control
// - Owner 1 with active sequence resumes generator
// - Owner 1 without sequence holds output 0 outside pulse-train stop
module poc_channel (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Controller stop pin
  input  wire logic        controller_stop,
  // Outputs to drive
  output logic             pulse_output_a,
  output logic             pulse_output_b,
  output logic             drive_enable_output,
  output logic             fast_stage_a,
  output logic             fast_stage_b
);
  // Bus state
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        next_wr_pend;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_hrdata;
  // Registers
  logic [31:0] ctrl;
  logic [31:0] period;
  logic [31:0] on_time;
  logic [31:0] step_half;
  logic [31:0] next_ctrl;
  logic [31:0] next_period;
  logic [31:0] next_on_time;
  logic [31:0] next_step_half;
  // Generator state
  logic        active;
  logic        enable_q;
  logic [31:0] cnt;
  logic [1:0]  phase;
  logic        gen_a;
  logic        gen_b;
  logic        next_active;
  logic        next_enable_q;
  logic [31:0] next_cnt;
  logic [1:0]  next_phase;
  logic        next_gen_a;
  logic        next_gen_b;
  // Output state
  logic        next_pulse_output_a;
  logic        next_pulse_output_b;
  logic        next_fast_stage_a;
  logic        next_fast_stage_b;
  logic        next_drive_enable_output;
  // Internal wires
  logic        stop_sync;
  logic        drv_req;
  logic        drv_limited;
  logic        drv_level;
  logic        drv_drop;
  logic        next_drv_drop;
  logic        a_limited;
  logic        b_limited;
  logic        a_target;
  logic        b_target;
  logic        pulse_train_mode;
  logic        owner;
  logic [31:0] wr_data;
  poc_pkg::poc_mode_t mode;

  assign mode  = poc_pkg::poc_mode_t'(ctrl[poc_pkg::CTRL_MODE_MSB:poc_pkg::CTRL_MODE_LSB]);
  assign pulse_train_mode = (mode != poc_pkg::POC_MODE_PWM) && (mode != poc_pkg::POC_MODE_FREQ);
  // Pulse-train modes ignore the owner bit, so direct control never applies there
  assign owner = ctrl[poc_pkg::CTRL_OWNER_BIT] | pulse_train_mode;

  poc_sync u_stop_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (controller_stop),
    .sync_out (stop_sync)
  );

  // Bus slave: zero wait state, always OKAY
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata  = hrdata;
    if (hsel && hready && htrans[1]) begin
      next_wr_addr = haddr[7:0];
      next_wr_pend = hwrite;
      if (!hwrite) begin
        case (haddr[7:0])
          poc_pkg::CTRL_ADDR:   next_hrdata = ctrl;
          poc_pkg::PERIOD_ADDR: next_hrdata = period;
          poc_pkg::ON_ADDR:     next_hrdata = on_time;
          poc_pkg::STEP_ADDR:   next_hrdata = step_half;
          poc_pkg::STATUS_ADDR: next_hrdata = {26'h000_0000, fast_stage_a,
                                               drive_enable_output, pulse_output_b,
                                               pulse_output_a, stop_sync, active};
          default:              next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  assign wr_data = hwdata;

  always_comb begin
    next_ctrl      = ctrl;
    next_period    = period;
    next_on_time   = on_time;
    next_step_half = step_half;
    if (wr_pend) begin
      case (wr_addr)
        poc_pkg::CTRL_ADDR:   next_ctrl      = wr_data;
        poc_pkg::PERIOD_ADDR: next_period    = wr_data;
        poc_pkg::ON_ADDR:     next_on_time   = wr_data;
        poc_pkg::STEP_ADDR:   next_step_half = wr_data;
        default:              next_ctrl      = ctrl;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ctrl      <= poc_pkg::CTRL_RESET;
      period    <= poc_pkg::PERIOD_RESET;
      on_time   <= poc_pkg::ON_RESET;
      step_half <= poc_pkg::STEP_RESET;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ctrl      <= next_ctrl;
      period    <= next_period;
      on_time   <= next_on_time;
      step_half <= next_step_half;
    end
  end

  // Generator: runs regardless of who owns the output
  always_comb begin
    next_enable_q = ctrl[poc_pkg::CTRL_ENABLE_BIT];
    next_active   = active;
    next_cnt      = cnt;
    next_phase    = phase;
    next_gen_a    = gen_a;
    next_gen_b    = gen_b;
    if (ctrl[poc_pkg::CTRL_ENABLE_BIT] && !enable_q) begin
      next_active = 1'b1;
      next_cnt    = 32'h0000_0000;
    end else if (!ctrl[poc_pkg::CTRL_ENABLE_BIT]) begin
      next_active = 1'b0;
    end
    if (stop_sync) begin
      // Zero velocity: sequence halts, tracks freeze
      next_active = 1'b0;
    end else if (active) begin
      case (mode)
        poc_pkg::POC_MODE_PWM, poc_pkg::POC_MODE_FREQ: begin
          next_cnt   = (cnt + 32'h0000_0001 >= period) ? 32'h0000_0000 : cnt + 32'h0000_0001;
          next_gen_a = (mode == poc_pkg::POC_MODE_FREQ) ? (cnt < (period >> 1)) : (cnt < on_time);
          next_gen_b = 1'b0;
        end
        default: begin
          if (cnt + 32'h0000_0001 >= step_half) begin
            next_cnt   = 32'h0000_0000;
            next_phase = phase + 2'h1;
          end else begin
            next_cnt = cnt + 32'h0000_0001;
          end
          case (mode)
            poc_pkg::POC_MODE_TRAIN_PULSE_DIR: begin
              next_gen_a = phase[0];
              next_gen_b = ctrl[poc_pkg::CTRL_DIR_BIT];
            end
            poc_pkg::POC_MODE_TRAIN_UP_DOWN: begin
              next_gen_a = phase[0] & ~ctrl[poc_pkg::CTRL_DIR_BIT];
              next_gen_b = phase[0] & ctrl[poc_pkg::CTRL_DIR_BIT];
            end
            default: begin
              next_gen_a = phase[1];
              next_gen_b = phase[1] ^ (phase[0] ^ ctrl[poc_pkg::CTRL_DIR_BIT]);
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= 1'b0;
      active   <= 1'b0;
      cnt      <= 32'h0000_0000;
      phase    <= 2'b00;
      gen_a    <= 1'b0;
      gen_b    <= 1'b0;
    end else begin
      enable_q <= next_enable_q;
      active   <= next_active;
      cnt      <= next_cnt;
      phase    <= next_phase;
      gen_a    <= next_gen_a;
      gen_b    <= next_gen_b;
    end
  end

  // Output selection
  always_comb begin
    if (!owner) begin
      a_target = ctrl[poc_pkg::CTRL_LEVEL_BIT];
    end else if (active) begin
      a_target = gen_a;
    end else if (stop_sync && pulse_train_mode) begin
      a_target = gen_a;
    end else begin
      a_target = 1'b0;
    end
    b_target = (active || (stop_sync && pulse_train_mode)) ? gen_b : 1'b0;
  end

  // Fast edges capped at 100 kHz toggle rate
  poc_rate_limit #(.MIN_CYCLES(poc_pkg::FAST_MIN_CYCLES)) u_lim_a (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .level_in  (a_target),
    .level_out (a_limited)
  );

  poc_rate_limit #(.MIN_CYCLES(poc_pkg::FAST_MIN_CYCLES)) u_lim_b (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .level_in  (b_target),
    .level_out (b_limited)
  );

  // Drive enable removal on stop is not configurable
  assign drv_req = ctrl[poc_pkg::CTRL_DRVCFG_BIT] & active & ~stop_sync;
  // An early drop also pulls the limiter low, so the next rise waits a full hold
  assign drv_level = drv_req & ~drv_drop;

  // Slow stage, 100 Hz; removal bypasses the hold so stop acts at once
  poc_rate_limit #(.MIN_CYCLES(poc_pkg::SLOW_MIN_CYCLES)) u_lim_drv (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .level_in  (drv_level),
    .level_out (drv_limited)
  );

  always_comb begin
    next_pulse_output_a      = a_limited;
    next_pulse_output_b      = b_limited;
    next_drive_enable_output = drv_limited & drv_level;
    next_drv_drop            = drv_limited & (drv_drop | ~drv_req);
    next_fast_stage_a        = pulse_train_mode | ctrl[poc_pkg::CTRL_FAST_BIT];
    next_fast_stage_b        = pulse_train_mode | ctrl[poc_pkg::CTRL_FAST_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_output_a      <= 1'b0;
      pulse_output_b      <= 1'b0;
      drive_enable_output <= 1'b0;
      drv_drop            <= 1'b0;
      fast_stage_a        <= 1'b0;
      fast_stage_b        <= 1'b0;
    end else begin
      pulse_output_a      <= next_pulse_output_a;
      pulse_output_b      <= next_pulse_output_b;
      drive_enable_output <= next_drive_enable_output;
      drv_drop            <= next_drv_drop;
      fast_stage_a        <= next_fast_stage_a;
      fast_stage_b        <= next_fast_stage_b;
    end
  end
endmodule : poc_channel

// *** verif/poc_channel_chk.sv ***
`timescale 1ns/1ps
module poc_channel_chk (
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic [1:0]  htrans,
  // Pins
  input wire logic        controller_stop,
  input wire logic        pulse_output_a,
  input wire logic        pulse_output_b,
  input wire logic        drive_enable_output,
  input wire logic        fast_stage_a,
  input wire logic        fast_stage_b
);
  localparam int HOLD = 60;
  logic [31:0] sc, next_sc;
  logic [15:0] cd, next_cd;
  logic [7:0]  ca, cb, cq, cs, next_ca, next_cb, next_cq, next_cs;
  logic        pend, pa, pb, pd, next_pend, pulse_train_mode;
  function automatic logic [7:0] up(input logic [7:0] c);
    return (c == 8'hff) ? c : c + 8'h01;
  endfunction : up
  // Control word shadow, so modes are known without peeking inside
  always_comb begin
    next_pend = hsel && hready && htrans[1] && hwrite && (haddr[7:0] == poc_pkg::CTRL_ADDR);
    next_sc = (pend && hready) ? hwdata : sc;
    next_ca = (pulse_output_a != pa) ? 8'h00 : up(ca);
    next_cb = (pulse_output_b != pb) ? 8'h00 : up(cb);
    next_cd = (drive_enable_output != pd) ? 16'h0000 : cd + {15'h0, cd != 16'hffff};
    next_cq = (next_sc != sc || controller_stop) ? 8'h00 : up(cq);
    next_cs = controller_stop ? up(cs) : 8'h00;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {pend, pa, pb, pd} <= 4'h0;
      sc <= poc_pkg::CTRL_RESET;
      {ca, cb, cq, cs} <= 32'hffff_0000;
      cd <= 16'hffff;
    end else begin
      {pend, pa, pb, pd} <= {next_pend, pulse_output_a, pulse_output_b, drive_enable_output};
      sc <= next_sc;
      {ca, cb, cq, cs} <= {next_ca, next_cb, next_cq, next_cs};
      cd <= next_cd;
    end
  end
  assign pulse_train_mode = sc[10:8] >= 3'h2;
  default clocking dclk @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_stop_drive_off: assert property (
    $rose(controller_stop) |-> ##[1:12] !drive_enable_output) else $error("drive on in stop");
  a_stop_tracks_hold: assert property (
    pulse_train_mode && cs >= HOLD |-> $stable(pulse_output_a) && $stable(pulse_output_b))
    else $error("track moved in stop");
  a_a_edge_space: assert property (
    $changed(pulse_output_a) |-> ca >= poc_pkg::FAST_MIN_CYCLES - 1) else $error("A too fast");
  a_b_edge_space: assert property (
    $changed(pulse_output_b) |-> cb >= poc_pkg::FAST_MIN_CYCLES - 1) else $error("B too fast");
  a_drive_slow: assert property (
    $rose(drive_enable_output) |-> cd >= poc_pkg::SLOW_MIN_CYCLES - 1) else $error("drive too fast");
  a_train_fast_stage: assert property (
    pulse_train_mode && cq >= 8 |-> fast_stage_a && fast_stage_b)
    else $error("slow stage in pulse train");
  a_fast_selectable: assert property (
    !pulse_train_mode && cq >= 8 |-> fast_stage_a == sc[4])
    else $error("fast stage not as selected");
  a_direct_follow: assert property (
    !pulse_train_mode && !sc[1] && cq >= HOLD |-> pulse_output_a == sc[3])
    else $error("A not direct level");
  a_owner_idle_zero: assert property (
    !pulse_train_mode && sc[1] && !sc[0] && cq >= HOLD |-> !pulse_output_a)
    else $error("idle A not low");
  c_stop: cover property (pulse_train_mode && cs == HOLD);
  c_direct: cover property (!pulse_train_mode && !sc[1] && cq == HOLD);
  c_drive_on: cover property ($rose(drive_enable_output));
endmodule : poc_channel_chk
bind poc_channel poc_channel_chk u_chk (.*);

// *** verif/poc_load.sv ***
`timescale 1ns/1ps
module poc_load (
  // Clock and reset
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // Step input of the drive
  input  wire logic   pulse_output_a,
  output logic [15:0] a_edges
);
  // Drive steps on rising edges only
  logic        prev_a, next_prev_a;
  logic [15:0] next_a_edges;
  always_comb begin
    next_prev_a = pulse_output_a;
    next_a_edges = a_edges + {15'h0, pulse_output_a & ~prev_a};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_a <= 1'b0;
      a_edges <= 16'h0000;
    end else begin
      prev_a <= next_prev_a;
      a_edges <= next_a_edges;
    end
  end
endmodule : poc_load

// *** verif/test_pulse_output_channel_control.sv ***
`timescale 1ns/1ps
module test_pulse_output_channel_control;
  logic        hclk, hresetn, hwrite, controller_stop, sa, sb, ow, lv;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [15:0] e0;
  wire logic   hreadyout, pulse_output_a, pulse_output_b;
  wire logic   drive_enable_output, fast_stage_a, fast_stage_b, hresp;
  wire logic [31:0] hrdata;
  wire logic [15:0] a_edges;
  int          failures, total_checks, n;
  poc_channel DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .controller_stop(controller_stop),
    .pulse_output_a(pulse_output_a), .pulse_output_b(pulse_output_b),
    .drive_enable_output(drive_enable_output), .fast_stage_a(fast_stage_a),
    .fast_stage_b(fast_stage_b));
  poc_load u_load (.hclk(hclk), .hresetn(hresetn), .pulse_output_a(pulse_output_a),
    .a_edges(a_edges));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  function automatic logic exp_a(input logic o, input logic l);
    return o ? 1'b0 : l;
  endfunction : exp_a
  function automatic logic exp_fast(input int m, input logic f);
    return (m >= 2) ? 1'b1 : f;
  endfunction : exp_fast
  function automatic logic enough(input int got, input int w, input int p);
    return got >= w / p - 1;
  endfunction : enough
  task stop_test;
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask : cyc
  task wait_rdy;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask : wait_rdy
  // Single word transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e, "register read");
  endtask : rdc
  initial begin
    {hresetn, hwrite, controller_stop, htrans, haddr, hwdata} = '0;
    {failures, total_checks} = '0;
    n = $urandom(32'hb756);
    cyc(3);
    hresetn <= 1'b1;
    rdc(poc_pkg::CTRL_ADDR, poc_pkg::CTRL_RESET);
    rdc(poc_pkg::PERIOD_ADDR, poc_pkg::PERIOD_RESET);
    rdc(poc_pkg::ON_ADDR, poc_pkg::ON_RESET);
    rdc(poc_pkg::STEP_ADDR, poc_pkg::STEP_RESET);
    rdc(8'h14, 32'h0);
    chk(hresp, 1'b0, "response not OKAY");
    $display("done: reset values");
    for (int m = 0; m < 6; m++) begin
      lv = 1'($urandom);
      bus(1'b1, poc_pkg::CTRL_ADDR, (32'(m) << 8) | (32'(lv) << 4) | 32'h2);
      cyc(8);
      bus(1'b0, poc_pkg::STATUS_ADDR, 32'h0);
      chk(rd[5], exp_fast(m, lv), "fast status");
      chk(fast_stage_a, exp_fast(m, lv), "fast pin");
      chk(fast_stage_b, exp_fast(m, lv), "fast pin B");
    end
    $display("done: modes");
    for (int i = 0; i < 8; i++) begin
      ow = (i < 2) ? i[0] : 1'($urandom);
      lv = (i < 2) ? 1'b1 : 1'($urandom);
      bus(1'b1, poc_pkg::CTRL_ADDR, (32'(lv) << 3) | (32'(ow) << 1));
      cyc(60);
      chk(pulse_output_a, exp_a(ow, lv), "direct A");
    end
    bus(1'b1, poc_pkg::CTRL_ADDR, 32'h0000_0208);
    cyc(60);
    chk(pulse_output_a, 1'b0, "direct in pulse train");
    $display("done: direct control");
    bus(1'b1, poc_pkg::CTRL_ADDR, 32'h0);
    bus(1'b1, poc_pkg::PERIOD_ADDR, 32'h0000_00c8);
    rdc(poc_pkg::PERIOD_ADDR, 32'h0000_00c8);
    bus(1'b1, poc_pkg::ON_ADDR, 32'h0000_0064);
    bus(1'b1, poc_pkg::CTRL_ADDR, 32'h0000_0003);
    cyc(100);
    bus(1'b1, poc_pkg::CTRL_ADDR, 32'h0000_0001);
    cyc(300);
    chk(pulse_output_a, 1'b0, "direct low while running");
    bus(1'b1, poc_pkg::CTRL_ADDR, 32'h0000_0003);
    e0 = a_edges;
    cyc(600);
    chk(enough(a_edges - e0, 600, 200), 1'b1, "no resume");
    bus(1'b0, poc_pkg::STATUS_ADDR, 32'h0);
    chk(rd[0], 1'b1, "sequence lost");
    $display("done: resume");
    // Count-down in up/down mode: pulses only on track B
    bus(1'b1, poc_pkg::CTRL_ADDR, 32'h0000_0343);
    cyc(60);
    {sa, sb, e0} = {1'b0, pulse_output_b, 16'h0000};
    repeat (400) begin
      @(posedge hclk);
      sa = sa | pulse_output_a;
      e0 = e0 + {15'h0, pulse_output_b != sb};
      sb = pulse_output_b;
    end
    chk(sa, 1'b0, "forward track moved");
    chk(enough(e0, 400, 50), 1'b1, "no reverse pulses");
    $display("done: track B");
    bus(1'b1, poc_pkg::CTRL_ADDR, 32'h0000_0200);
    bus(1'b1, poc_pkg::CTRL_ADDR, 32'h0000_0223);
    n = 0;
    while (drive_enable_output !== 1'b1 && n < 60000) begin
      @(posedge hclk);
      n++;
    end
    chk(drive_enable_output, 1'b1, "drive never on");
    controller_stop <= 1'b1;
    cyc(12);
    chk(drive_enable_output, 1'b0, "drive on in stop");
    cyc(60);
    {sa, sb} = {pulse_output_a, pulse_output_b};
    cyc(100);
    chk({pulse_output_a, pulse_output_b}, {sa, sb}, "tracks moved");
    bus(1'b0, poc_pkg::STATUS_ADDR, 32'h0);
    chk(rd[0], 1'b0, "active in stop");
    controller_stop <= 1'b0;
    cyc(10);
    $display("done: stop");
    stop_test();
  end
endmodule : test_pulse_output_channel_control
